// [inc/srx_pkg.sv]
/*
  Package for the subroutine-exit / rotate-through-carry execution block.
  Holds opcode patterns, field positions, flag bit positions, reset values
  and the register map of the AXI4-Lite control port.
  Assumes a 32-bit AXI4-Lite bus with word-aligned registers.
*/
package srx_pkg;

  // ----------------------------------------------------------------
  // Opcode patterns
  // ----------------------------------------------------------------
  localparam logic [15:0] SRX_EXIT_MASK = 16'hFFFE;
  localparam logic [15:0] SRX_EXIT_CODE = 16'h0012;
  localparam logic [15:0] SRX_ROT_MASK = 16'hFC00;
  localparam logic [15:0] SRX_ROT_CODE = 16'h3400;
  localparam logic [15:0] SRX_LIT_MASK = 16'hFF00;
  localparam logic [15:0] SRX_LIT_CODE = 16'h0C00;

  // ----------------------------------------------------------------
  // Opcode fields
  // ----------------------------------------------------------------
  localparam int SRX_FAST_BIT = 0;
  localparam int SRX_DEST_BIT = 9;
  localparam int SRX_ACC_BIT = 8;
  localparam logic [7:0] SRX_IDX_LIMIT = 8'h5F;
  localparam logic [7:0] SRX_ACC_SPLIT = 8'h60;
  localparam logic [3:0] SRX_ACC_HI_BANK = 4'hF;

  // ----------------------------------------------------------------
  // Flag bit positions
  // ----------------------------------------------------------------
  localparam int SRX_FLAG_C = 0;
  localparam int SRX_FLAG_Z = 2;
  localparam int SRX_FLAG_N = 4;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SRX_REG_INSTR = 8'h00;
  localparam logic [7:0] SRX_REG_WORK = 8'h04;
  localparam logic [7:0] SRX_REG_FLAGS = 8'h08;
  localparam logic [7:0] SRX_REG_BANK = 8'h0C;
  localparam logic [7:0] SRX_REG_SHADOW = 8'h10;
  localparam logic [7:0] SRX_REG_STACK = 8'h14;
  localparam logic [7:0] SRX_REG_PC = 8'h18;
  localparam logic [7:0] SRX_REG_FILE = 8'h1C;
  localparam logic [7:0] SRX_REG_CTRL = 8'h20;
  localparam logic [7:0] SRX_REG_FSR = 8'h24;
  localparam logic [7:0] SRX_REG_WADDR = 8'h28;
  localparam logic [7:0] SRX_RST_BYTE = 8'h00;
  localparam logic [20:0] SRX_RST_PC = 21'h000000;
  localparam logic [1:0] SRX_RESP_OKAY = 2'h0;
  localparam logic [1:0] SRX_RESP_SLVERR = 2'h2;

endpackage

// [core/srx_exec.sv]
/*
  Combinational execution unit for the three opcodes.
  Assumes operands are current registered state of the caller.
*/
`timescale 1ns/1ns
module srx_exec
  import srx_pkg::*;
(
  input wire logic [15:0] opcode,
  input wire logic ext_set,
  input wire logic [7:0] work,
  input wire logic [7:0] flags,
  input wire logic [3:0] bank,
  input wire logic [7:0] file_rd,
  input wire logic [11:0] fsr2,
  output logic is_exit,
  output logic is_rot,
  output logic is_lit,
  output logic fast,
  output logic to_file,
  output logic [11:0] file_addr,
  output logic [7:0] result,
  output logic [7:0] flags_out
);

  always_comb begin
    is_exit = (opcode & SRX_EXIT_MASK) == SRX_EXIT_CODE;
    is_rot = (opcode & SRX_ROT_MASK) == SRX_ROT_CODE;
    is_lit = (opcode & SRX_LIT_MASK) == SRX_LIT_CODE;
    fast = opcode[SRX_FAST_BIT];
    to_file = opcode[SRX_DEST_BIT]; // see [RULE_06]
    // Address: banked, access bank, or indexed off FSR2
    if (opcode[SRX_ACC_BIT]) begin
      file_addr = {bank, opcode[7:0]}; // see [RULE_07] see [RULE_10]
    end else if (ext_set && opcode[7:0] <= SRX_IDX_LIMIT) begin
      file_addr = fsr2 + {4'h0, opcode[7:0]}; // see [RULE_08]
    end else if (opcode[7:0] < SRX_ACC_SPLIT) begin
      file_addr = {4'h0, opcode[7:0]}; // see [RULE_07]
    end else begin
      file_addr = {SRX_ACC_HI_BANK, opcode[7:0]};
    end
    result = {file_rd[6:0], flags[SRX_FLAG_C]}; // see [RULE_05]
    flags_out = flags;
    flags_out[SRX_FLAG_C] = file_rd[7]; // see [RULE_05]
    flags_out[SRX_FLAG_N] = result[7]; // see [RULE_09]
    flags_out[SRX_FLAG_Z] = result == 8'h00; // see [RULE_09]
  end

endmodule

// [core/srx_core.sv]
/*
  Subroutine-exit and rotate-through-carry execution block with an
  AXI4-Lite slave for software access to core state.
  Assumes one clock, synchronous active-low reset, one outstanding
  write and one outstanding read from the master.
*/
// The register addresses and register access over AXI4-Lite are this design's own decisions.
// Summary of operation
// [RULE_01] Exit pops stack top into program counter
// [RULE_02] Fast exit restores work, flags, bank
// [RULE_03] Normal exit leaves work, flags, bank
// [RULE_04] Exit keeps PC latches and, unless fast, flags
// [RULE_05] Rotate left through carry bit
// [RULE_06] Destination bit picks work or file
// [RULE_07] Access bit picks access or banked
// [RULE_08] Extended set, low address: indexed mode
// [RULE_09] Negative and zero follow the result
// [RULE_10] File address is eight low bits
// [RULE_11] Literal return loads work, pops stack
`timescale 1ns/1ns
module srx_core
  import srx_pkg::*;
#(
  parameter int STACK_DEPTH = 31,
  parameter int FILE_WORDS = 4096
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [20:0] pc_out
);

  localparam int SPW = $clog2(STACK_DEPTH + 1);

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic awready;
    logic wready;
    logic arready;
    logic [7:0] work;
    logic [7:0] flags;
    logic [3:0] bank;
    logic [7:0] sh_work;
    logic [7:0] sh_flags;
    logic [3:0] sh_bank;
    logic [7:0] pc_upper_latch;
    logic [7:0] pc_high_latch;
    logic [20:0] pc;
    logic [SPW-1:0] sp;
    logic ext_set;
    logic [11:0] fsr2;
    logic [11:0] waddr;
  } srx_state_s;

  srx_state_s st_q, st_d;
  logic [20:0] stack_mem [STACK_DEPTH];
  logic [7:0] file_mem [FILE_WORDS];

  logic is_exit, is_rot, is_lit, fast, to_file;
  logic [11:0] file_addr;
  logic [7:0] result, flags_new, file_rd;
  logic [15:0] exec_op;
  logic do_exec, do_push, do_fwr, do_fdirect, stack_ne;
  logic [20:0] stack_top;
  logic [7:0] fwr_data;
  logic [11:0] fwr_addr;
  logic rd_fire;

  assign exec_op = st_q.wdata[15:0];
  assign file_rd = file_mem[file_addr];
  assign stack_ne = st_q.sp != '0;
  assign stack_top = stack_ne ? stack_mem[st_q.sp - SPW'(1)] : SRX_RST_PC;

  srx_exec u_exec (
    .opcode(exec_op),
    .ext_set(st_q.ext_set),
    .work(st_q.work),
    .flags(st_q.flags),
    .bank(st_q.bank),
    .file_rd(file_rd),
    .fsr2(st_q.fsr2),
    .is_exit(is_exit),
    .is_rot(is_rot),
    .is_lit(is_lit),
    .fast(fast),
    .to_file(to_file),
    .file_addr(file_addr),
    .result(result),
    .flags_out(flags_new)
  );

  // ----------------------------------------------------------------
  // Write / read decode and state update
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    do_exec = 1'b0;
    do_push = 1'b0;
    do_fdirect = 1'b0;
    rd_fire = s_axi_arvalid && !st_q.rvalid;
    if (s_axi_awvalid && !st_q.aw_got && !st_q.bvalid) begin
      st_d.aw_got = 1'b1;
      st_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_q.w_got && !st_q.bvalid) begin
      st_d.w_got = 1'b1;
      st_d.wdata = s_axi_wdata;
    end
    if (st_q.aw_got && st_q.w_got) begin
      st_d.aw_got = 1'b0;
      st_d.w_got = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = SRX_RESP_OKAY;
      case (st_q.awaddr)
        SRX_REG_INSTR: do_exec = 1'b1;
        SRX_REG_WORK: st_d.work = st_q.wdata[7:0];
        SRX_REG_FLAGS: st_d.flags = st_q.wdata[7:0];
        SRX_REG_BANK: st_d.bank = st_q.wdata[3:0];
        SRX_REG_SHADOW: begin
          st_d.sh_work = st_q.wdata[7:0];
          st_d.sh_flags = st_q.wdata[15:8];
          st_d.sh_bank = st_q.wdata[19:16];
        end
        SRX_REG_STACK: do_push = st_q.sp != SPW'(STACK_DEPTH);
        SRX_REG_FILE: do_fdirect = 1'b1;
        SRX_REG_CTRL: begin
          st_d.ext_set = st_q.wdata[0];
          st_d.pc_upper_latch = st_q.wdata[15:8];
          st_d.pc_high_latch = st_q.wdata[23:16];
        end
        SRX_REG_FSR: st_d.fsr2 = st_q.wdata[11:0];
        SRX_REG_WADDR: st_d.waddr = st_q.wdata[11:0];
        default: st_d.bresp = SRX_RESP_SLVERR;
      endcase
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (do_push) begin
      st_d.sp = st_q.sp + SPW'(1);
    end
    // Exit and literal return never touch the PC latches
    if (do_exec && (is_exit || is_lit)) begin
      st_d.pc = stack_top; // see [RULE_01] see [RULE_04] see [RULE_11]
      if (stack_ne) begin
        st_d.sp = st_q.sp - SPW'(1);
      end
      if (is_lit) begin
        st_d.work = exec_op[7:0]; // see [RULE_11]
      end else if (fast) begin
        st_d.work = st_q.sh_work; // see [RULE_02]
        st_d.flags = st_q.sh_flags;
        st_d.bank = st_q.sh_bank;
      end // Otherwise nothing else changes, see [RULE_03]
    end
    if (do_exec && is_rot) begin
      st_d.flags = flags_new; // see [RULE_05] see [RULE_09]
      if (!to_file) begin
        st_d.work = result; // see [RULE_06]
      end
      st_d.pc = st_q.pc + 21'h000002;
    end
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (rd_fire) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = SRX_RESP_OKAY;
      st_d.rdata = 32'h00000000;
      case (s_axi_araddr)
        SRX_REG_INSTR: st_d.rdata = {16'h0000, exec_op};
        SRX_REG_WORK: st_d.rdata[7:0] = st_q.work;
        SRX_REG_FLAGS: st_d.rdata[7:0] = st_q.flags;
        SRX_REG_BANK: st_d.rdata[3:0] = st_q.bank;
        SRX_REG_SHADOW: st_d.rdata[19:0] = {st_q.sh_bank, st_q.sh_flags, st_q.sh_work};
        SRX_REG_STACK: st_d.rdata = {3'h0, 8'(st_q.sp), stack_top};
        SRX_REG_PC: st_d.rdata[20:0] = st_q.pc;
        SRX_REG_FILE: st_d.rdata[7:0] = file_mem[st_q.waddr];
        SRX_REG_CTRL: st_d.rdata[23:0] = {st_q.pc_high_latch, st_q.pc_upper_latch,
                                          7'h00, st_q.ext_set};
        SRX_REG_FSR: st_d.rdata[11:0] = st_q.fsr2;
        SRX_REG_WADDR: st_d.rdata[11:0] = st_q.waddr;
        default: st_d.rresp = SRX_RESP_SLVERR;
      endcase
    end
    if (!aresetn) begin
      st_d = '0;
      st_d.pc = SRX_RST_PC;
      st_d.work = SRX_RST_BYTE;
    end
    // Readies are registered from the next state, so they match the old gate timing
    st_d.awready = !st_d.aw_got && !st_d.bvalid;
    st_d.wready = !st_d.w_got && !st_d.bvalid;
    st_d.arready = !st_d.rvalid;
  end

  // File write: rotate back to file, or direct software write
  always_comb begin
    do_fwr = 1'b0;
    fwr_addr = st_q.waddr;
    fwr_data = st_q.wdata[7:0];
    if (do_exec && is_rot && to_file) begin
      do_fwr = 1'b1; // see [RULE_06]
      fwr_addr = file_addr;
      fwr_data = result;
    end else if (do_fdirect) begin
      do_fwr = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    st_q <= st_d;
    if (do_push) begin
      stack_mem[st_q.sp] <= st_q.wdata[20:0];
    end
    if (do_fwr) begin
      file_mem[fwr_addr] <= fwr_data;
    end
  end

  assign s_axi_awready = st_q.awready;
  assign s_axi_wready = st_q.wready;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;
  assign pc_out = st_q.pc;

endmodule

// [sim/srx_core_props.sv]
/*
  Port-level checks of srx_core: handshake timing, response hold, program counter.
  Assumes binding to srx_core, one clock, synchronous active-low reset.
*/
`timescale 1ns/1ns
module srx_core_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [20:0] pc_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Program counter moves only with an executed opcode, never on its own
  chk_pc_hold: assert property (!$stable(pc_out) |-> $rose(s_axi_bvalid))
    else $error("pc_out changed without an executed opcode");
  chk_write_lat: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response not two edges after capture");
  chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one edge after address");
  chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  chk_b_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel open while response pending");
  chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open while data pending");
  chk_b_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response stayed after taken");
endmodule

// [sim/tb_srx_core.sv]
/*
  Bench for srx_core: exit, rotate, literal return and unmapped access over AXI4-Lite.
  Assumes the register map of srx_pkg and the checker in srx_core_props.
*/
`timescale 1ns/1ns
module tb_srx_core;
  import srx_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [20:0] pc_out;
  int bad_count = 0;
  int total_checks = 0;

  srx_core srx_core_i (.*);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  // Answer readies go up with the request; one idle edge after each access keeps
  // the next call from driving the same signal in that time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
    if (n >= 50) bad_count++;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    if (n >= 50) bad_count++;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_exit(input logic fast);
    wr(SRX_REG_WORK, 32'h11);
    wr(SRX_REG_FLAGS, 32'h0A);
    wr(SRX_REG_BANK, 32'h3);
    wr(SRX_REG_SHADOW, 32'h000A_9BC4);
    wr(SRX_REG_CTRL, 32'h00CD_AB00);
    wr(SRX_REG_STACK, 32'h0001_2346);
    wr(SRX_REG_INSTR, {16'h0, SRX_EXIT_CODE | {15'h0, fast}});
    chk("pc_out", pc_out, 32'h1_2346);
    rd(SRX_REG_WORK);
    chk("work", rdat[7:0], fast ? 8'hC4 : 8'h11);
    rd(SRX_REG_FLAGS);
    chk("flags", rdat[7:0], fast ? 8'h9B : 8'h0A);
    rd(SRX_REG_BANK);
    chk("bank", rdat[3:0], fast ? 4'hA : 4'h3);
    rd(SRX_REG_CTRL);
    chk("latches", rdat[23:8], 16'hCDAB);
    $display("exit test done, fast %0d", fast);
  endtask

  task automatic t_rot(input logic [9:0] low, input logic ext, input logic [3:0] bank,
      input logic [11:0] fsr, input logic [11:0] addr, input logic [7:0] v, input logic c);
    logic [7:0] res;
    logic [7:0] fl;
    res = {v[6:0], c};
    fl = {3'b111, res[7], 1'b1, res == 8'h0, 1'b0, v[7]};
    wr(SRX_REG_CTRL, {31'h0, ext});
    wr(SRX_REG_BANK, {28'h0, bank});
    wr(SRX_REG_FSR, {20'h0, fsr});
    wr(SRX_REG_WADDR, {20'h0, addr});
    wr(SRX_REG_FILE, {24'h0, v});
    // Untouched flag bits 3, 5, 6 and 7 set, so a rotate that clobbers them shows
    wr(SRX_REG_FLAGS, {24'h0, 8'hE8 | {7'h0, c}});
    wr(SRX_REG_WORK, 32'h55);
    wr(SRX_REG_INSTR, {16'h0, SRX_ROT_CODE | {6'h0, low}});
    rd(SRX_REG_FILE);
    chk("file", rdat[7:0], low[9] ? res : v);
    rd(SRX_REG_WORK);
    chk("work", rdat[7:0], low[9] ? 8'h55 : res);
    rd(SRX_REG_FLAGS);
    chk("flags", rdat[7:0], fl);
    $display("rotate test done, opcode low %h", low);
  endtask

  task automatic t_misc();
    wr(SRX_REG_STACK, 32'h0000_ABCD);
    wr(SRX_REG_INSTR, {16'h0, SRX_LIT_CODE | 16'h005A});
    chk("pc_out", pc_out, 32'hABCD);
    rd(SRX_REG_WORK);
    chk("work", rdat[7:0], 8'h5A);
    wr(8'h2C, 32'h1);
    chk("bresp", resp, SRX_RESP_SLVERR);
    rd(8'h2C);
    chk("rresp", resp, SRX_RESP_SLVERR);
    $display("literal and unmapped test done");
  endtask

  initial begin
    aresetn <= 1'b0;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    s_axi_awaddr <= 8'h00;
    s_axi_araddr <= 8'h00;
    s_axi_wdata <= 32'h0;
    s_axi_wstrb <= 4'hF;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("pc_out reset", pc_out, SRX_RST_PC);
    t_exit(1'b0);
    t_exit(1'b1);
    t_rot(10'h225, 1'b0, 4'h0, 12'h000, 12'h025, 8'hE6, 1'b0);
    t_rot(10'h080, 1'b0, 4'h0, 12'h000, 12'hF80, 8'h80, 1'b0);
    t_rot(10'h312, 1'b0, 4'h3, 12'h000, 12'h312, 8'h01, 1'b1);
    t_rot(10'h25F, 1'b1, 4'h0, 12'h200, 12'h25F, 8'h7F, 1'b1);
    t_rot(10'h060, 1'b1, 4'h0, 12'h200, 12'hF60, 8'h40, 1'b0);
    t_misc();
    print_verdict();
  end

  initial begin
    #100000;
    bad_count++;
    print_verdict();
  end
endmodule

bind srx_core srx_core_props srx_core_props_i (.*);
